// File: icc_top.sv
`timescale 1ns/1ps
module icc_top import icc_pkg::*; #(
  parameter int TICK_CYCLES = ICC_TICK_CYCLES  // Cycles per 100 ms tick
) (
  input  logic        pclk,          // APB clock
  input  logic        presetn,       // Async reset, active low
  input  logic        psel,          // APB select
  input  logic        penable,       // APB enable
  input  logic        pwrite,        // APB direction
  input  logic [11:0] paddr,         // APB byte address
  input  logic [31:0] pwdata,        // APB write data
  output logic [31:0] prdata,        // APB read data
  output logic        pready,        // APB ready
  output logic        pslverr,       // Unmapped address
  input  logic [7:0]  in_contact,    // Contact pins, inputs 1..8
  input  logic [7:0]  in_short,      // Short-circuit comparator
  input  logic [7:0]  in_open,       // Open-circuit comparator
  input  logic        mains_fail,    // Mains lost, on battery
  input  icc_grant_s  grant,         // Reader access granted
  input  logic        timed_reset,   // Time-of-day reset pulse
  output logic [36:1] relay_drive,   // Relay requests
  output logic [1:0]  door_open,     // Door sense per door
  output logic [1:0]  egress_start,  // Lock release pulse
  output logic [1:0]  egress_hold,   // Hold lock released
  output logic [2:0]  access_mode,   // Card+PIN, PIN, card
  output logic [7:0]  floor_select,  // Lift floors 1..8
  output icc_event_s  evt            // Input event message
);

  // Default use resolves by mode and input number
  function automatic logic [4:0] eff_use(input int i, input logic [31:0] cfg, input logic [1:0] m);
    logic [3:0] u;
    logic       d;
    u = {1'b0, cfg[F_USE +: 3]};
    d = cfg[F_DOOR];
    if (u == USE_DEFAULT) begin
      u = USE_NONE;
      d = (i >= 3);
      if (m == lift_control_mode && i >= 1) begin
        u = USE_FLOOR;
      end else if (i >= 1 && (i <= 2 || (i <= 4 && m == two_reader_two_door_mode))) begin
        u = (i % 2 == 1) ? USE_SENSE : USE_EGRESS;
      end
    end
    eff_use = {d, u};
  endfunction : eff_use

  // Relay number to one-hot, zero or out of range drives none
  function automatic logic [36:1] relay_bit(input logic [5:0] s);
    relay_bit = '0;
    if (s != 6'h00 && s <= RLY_MAX) begin
      relay_bit[s] = 1'b1;
    end
  endfunction : relay_bit

  function automatic logic [11:0] in_addr(input int i, input int off);
    in_addr = 12'(int'(A_IN_BASE) + i * IN_STRIDE + off);
  endfunction : in_addr

  function automatic logic [11:0] cnt_addr(input int c, input int off);
    cnt_addr = 12'(int'(A_CNT_BASE) + c * CNT_STRIDE + off);
  endfunction : cnt_addr

  // Pin synchronisers, first stage feeds only the second
  logic [24:0] sync1;
  logic [24:0] sync2;
  logic [7:0]  s_contact;
  logic [7:0]  s_short;
  logic [7:0]  s_open;
  logic        s_mains;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {mains_fail, in_open, in_short, in_contact};
      sync2 <= sync1;
    end
  end
  assign {s_mains, s_open, s_short, s_contact} = sync2;

  // Register file state
  logic [1:0]  mode;
  logic [5:0]  flt_rly;
  logic [31:0] in_cfg [N_IN];
  logic [31:0] in_dly [N_IN];
  logic [1:0]  next_mode;
  logic [5:0]  next_flt_rly;
  logic [31:0] next_in_cfg [N_IN];
  logic [31:0] next_in_dly [N_IN];
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        wr_go;

  // Counter state
  logic [15:0] cnt_val [N_CNT];
  logic [15:0] cnt_rst [N_CNT];
  logic [1:0]  cnt_opt [N_CNT];
  logic [15:0] lim_val [N_CNT][N_LIM];
  logic [15:0] lim_hys [N_CNT][N_LIM];
  logic [5:0]  lim_rly [N_CNT][N_LIM];
  logic        lim_on  [N_CNT][N_LIM];
  logic [15:0] next_cnt_val [N_CNT];
  logic [15:0] next_cnt_rst [N_CNT];
  logic [1:0]  next_cnt_opt [N_CNT];
  logic [15:0] next_lim_val [N_CNT][N_LIM];
  logic [15:0] next_lim_hys [N_CNT][N_LIM];
  logic [5:0]  next_lim_rly [N_CNT][N_LIM];
  logic        next_lim_on  [N_CNT][N_LIM];

  // Input conditioning state
  logic [23:0]     tick_cnt;
  logic            tick;
  logic [N_IN-1:0] raw_prev;
  logic [N_IN-1:0] qual;
  logic [N_IN-1:0] qual_prev;
  logic [N_IN-1:0] flt;
  logic [N_IN-1:0] pend;
  logic [12:0]     tmr [N_IN];
  logic [23:0]     next_tick_cnt;
  logic            next_tick;
  logic [N_IN-1:0] next_raw_prev;
  logic [N_IN-1:0] next_qual;
  logic [N_IN-1:0] next_flt;
  logic [N_IN-1:0] next_pend;
  logic [12:0]     next_tmr [N_IN];
  icc_event_s      next_evt;
  logic [N_IN-1:0] on_edge;

  // Write lands only at the edge where the master sees pready
  assign wr_go   = psel & penable & pwrite & pready;
  assign on_edge = qual & ~qual_prev;

  // APB slave: one wait state so read data leaves a flop
  always_comb begin
    logic [31:0] rd;
    logic        hit;
    rd           = '0;
    hit          = 1'b0;
    next_pready  = psel & penable & ~pready;
    next_prdata  = '0;
    next_pslverr = 1'b0;
    next_mode    = mode;
    next_flt_rly = flt_rly;
    next_in_cfg  = in_cfg;
    next_in_dly  = in_dly;
    if (paddr == A_CTRL) begin
      rd  = {30'h0, mode};
      hit = 1'b1;
      if (wr_go) next_mode = pwdata[1:0];
    end
    if (paddr == A_STATUS) begin
      rd  = {7'h0, flt, 7'h0, qual};  // Qualified states and faults
      hit = 1'b1;
    end
    if (paddr == A_FLT_RELAY) begin
      rd  = {26'h0, flt_rly};
      hit = 1'b1;
      if (wr_go) next_flt_rly = pwdata[5:0];
    end
    for (int i = 0; i < N_IN; i++) begin
      if (paddr == in_addr(i, OFF_CFG)) begin
        rd  = in_cfg[i];
        hit = 1'b1;
        if (wr_go) begin
          next_in_cfg[i] = pwdata & CFG_MASK;
          if (i == 0) next_in_cfg[i][F_TYPE +: 2] = TYPE_DIGITAL;
        end
      end
      if (paddr == in_addr(i, OFF_DLY)) begin
        rd  = in_dly[i];
        hit = 1'b1;
        if (wr_go) next_in_dly[i] = pwdata & DLY_MASK;
      end
    end
    for (int c = 0; c < N_CNT; c++) begin
      if (paddr == cnt_addr(c, OFF_VAL)) begin
        rd  = {16'h0, cnt_val[c]};
        hit = 1'b1;
      end
      if (paddr == cnt_addr(c, OFF_RST)) begin
        rd  = {14'h0, cnt_opt[c], cnt_rst[c]};
        hit = 1'b1;
      end
      if (paddr == cnt_addr(c, OFF_RLY)) begin
        for (int l = 0; l < N_LIM; l++) rd[l * RLY_STRIDE +: 6] = lim_rly[c][l];
        hit = 1'b1;
      end
      for (int l = 0; l < N_LIM; l++) begin
        if (paddr == cnt_addr(c, OFF_LIM + 4 * l)) begin
          rd  = {lim_hys[c][l], lim_val[c][l]};
          hit = 1'b1;
        end
      end
    end
    if (next_pready) begin
      next_prdata  = pwrite ? 32'h0 : rd;
      next_pslverr = ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
      mode    <= two_reader_two_door_mode;
      flt_rly <= '0;
      for (int i = 0; i < N_IN; i++) begin
        in_cfg[i] <= CFG_RST;
        in_dly[i] <= '0;
      end
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
      mode    <= next_mode;
      flt_rly <= next_flt_rly;
      in_cfg  <= next_in_cfg;
      in_dly  <= next_in_dly;
    end
  end

  // Input qualification, supervision and event queue
  always_comb begin
    logic        raw;
    logic [12:0] dly;
    logic [N_IN-1:0] clr;
    raw           = 1'b0;
    dly           = '0;
    clr           = '0;
    next_tick     = (tick_cnt == 24'(TICK_CYCLES - 1));
    next_tick_cnt = next_tick ? 24'h0 : tick_cnt + 24'h1;
    next_raw_prev = raw_prev;
    next_qual     = qual;
    next_flt      = flt;
    next_tmr      = tmr;
    next_evt      = '0;
    for (int i = 0; i < N_IN; i++) begin
      raw = ((i == 0) ? s_mains : s_contact[3'(i - 1)]) ^ in_cfg[i][F_POL];
      dly = raw ? in_dly[i][0 +: 13] : in_dly[i][F_OFFD +: 13];
      next_raw_prev[i] = raw;
      if (raw != raw_prev[i] || raw == qual[i]) begin
        next_tmr[i] = '0;
      end else if (tmr[i] >= dly) begin
        next_qual[i] = raw;
        next_tmr[i]  = '0;
      end else if (tick) begin
        next_tmr[i] = tmr[i] + 13'h1;
      end
      next_flt[i] = 1'b0;
      if (i != 0) begin
        case (in_cfg[i][F_TYPE +: 2])
          TYPE_TWO_RES: next_flt[i] = s_short[3'(i - 1)] | s_open[3'(i - 1)];
          TYPE_ONE_RES: next_flt[i] = s_short[3'(i - 1)];
          default:      next_flt[i] = 1'b0;
        endcase
      end
    end
    // Lowest pending input goes out first, one message a cycle
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (pend[i]) begin
        clr      = '0;
        clr[i]   = 1'b1;
        next_evt = '{valid: 1'b1, idx: 4'(i), state: qual[i], fault: flt[i]};
      end
    end
    // A new change beats the clear of the same bit
    next_pend = (pend & ~clr) | (next_qual ^ qual) | (next_flt ^ flt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt  <= '0;
      tick      <= 1'b0;
      raw_prev  <= '0;
      qual      <= '0;
      qual_prev <= '0;
      flt       <= '0;
      pend      <= '0;
      evt       <= '0;
      for (int i = 0; i < N_IN; i++) tmr[i] <= '0;
    end else begin
      tick_cnt  <= next_tick_cnt;
      tick      <= next_tick;
      raw_prev  <= next_raw_prev;
      qual      <= next_qual;
      qual_prev <= qual;
      flt       <= next_flt;
      pend      <= next_pend;
      evt       <= next_evt;
      tmr       <= next_tmr;
    end
  end

  // Counters: software writes, input and grant steps, resets, limits
  always_comb begin
    int          inc;
    int          dec;
    int          sum;
    logic        do_rst;
    logic [15:0] base;
    inc          = 0;
    dec          = 0;
    sum          = 0;
    do_rst       = 1'b0;
    base         = '0;
    next_cnt_val = cnt_val;
    next_cnt_rst = cnt_rst;
    next_cnt_opt = cnt_opt;
    next_lim_val = lim_val;
    next_lim_hys = lim_hys;
    next_lim_rly = lim_rly;
    next_lim_on  = lim_on;
    for (int c = 0; c < N_CNT; c++) begin
      base = cnt_val[c];
      if (wr_go && paddr == cnt_addr(c, OFF_VAL)) base = pwdata[15:0];
      inc = 0;
      dec = 0;
      for (int i = 0; i < N_IN; i++) begin
        if (on_edge[i] && in_cfg[i][F_UP +: 5] == 5'(c + 1)) inc = inc + 1;
        if (on_edge[i] && in_cfg[i][F_DN +: 5] == 5'(c + 1)) dec = dec + 1;
      end
      if (grant.valid && grant.up == 5'(c + 1)) inc = inc + 1;
      if (grant.valid && grant.dn == 5'(c + 1)) dec = dec + 1;
      sum = int'(base) + inc - dec;
      if (sum < 0) sum = 0;
      if (sum > 65535) sum = 65535;
      do_rst = (cnt_opt[c] == OPT_NOW) || (cnt_opt[c] == OPT_TIMED && timed_reset);
      if (do_rst) sum = int'(cnt_rst[c]);
      if (cnt_opt[c] == OPT_NOW) next_cnt_opt[c] = OPT_NEVER;
      next_cnt_val[c] = 16'(sum);
      if (wr_go && paddr == cnt_addr(c, OFF_RST)) begin
        next_cnt_rst[c] = pwdata[15:0];
        next_cnt_opt[c] = pwdata[F_OPT +: 2];
      end
      for (int l = 0; l < N_LIM; l++) begin
        if (wr_go && paddr == cnt_addr(c, OFF_RLY)) next_lim_rly[c][l] = pwdata[l * RLY_STRIDE +: 6];
        if (wr_go && paddr == cnt_addr(c, OFF_LIM + 4 * l)) begin
          next_lim_val[c][l] = pwdata[15:0];
          next_lim_hys[c][l] = pwdata[F_HYS +: 16];
        end
        // Release on a counter reset, or once value plus hysteresis is below the limit
        if (do_rst) begin
          next_lim_on[c][l] = 1'b0;
        end else if (cnt_val[c] >= lim_val[c][l]) begin
          next_lim_on[c][l] = 1'b1;
        end else if (({1'b0, cnt_val[c]} + {1'b0, lim_hys[c][l]}) < {1'b0, lim_val[c][l]}) begin
          next_lim_on[c][l] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < N_CNT; c++) begin
        cnt_val[c] <= '0;
        cnt_rst[c] <= '0;
        cnt_opt[c] <= OPT_NEVER;
        for (int l = 0; l < N_LIM; l++) begin
          lim_val[c][l] <= '0;
          lim_hys[c][l] <= '0;
          lim_rly[c][l] <= '0;
          lim_on[c][l]  <= 1'b0;
        end
      end
    end else begin
      cnt_val <= next_cnt_val;
      cnt_rst <= next_cnt_rst;
      cnt_opt <= next_cnt_opt;
      lim_val <= next_lim_val;
      lim_hys <= next_lim_hys;
      lim_rly <= next_lim_rly;
      lim_on  <= next_lim_on;
    end
  end

  // Output map: relays, doors, access modes, floors
  logic [36:1] next_relay;
  logic [1:0]  next_door;
  logic [1:0]  next_egs;
  logic [1:0]  next_egh;
  logic [2:0]  next_acc;
  logic [7:0]  next_floor;
  always_comb begin
    logic [4:0]  du;
    logic [36:1] lock_mask;
    du         = '0;
    lock_mask  = '0;
    next_relay = '0;
    next_door  = '0;
    next_egs   = '0;
    next_egh   = '0;
    next_acc   = '0;
    next_floor = '0;
    // Lock relay 1 is kept from input-follow relays outside lift mode, relay 2 only in two-door mode; fault and limit relays are not masked
    if (mode != lift_control_mode) lock_mask = relay_bit(LOCK_RLY_A);
    if (mode == two_reader_two_door_mode) lock_mask = lock_mask | relay_bit(LOCK_RLY_B);
    for (int i = 0; i < N_IN; i++) begin
      du = eff_use(i, in_cfg[i], mode);
      if (qual[i]) begin
        case (du[3:0])
          USE_SENSE:    next_door[du[4]] = 1'b1;
          USE_EGRESS:   next_egh[du[4]]  = 1'b1;
          USE_RELAY:    next_relay = next_relay | (relay_bit(in_cfg[i][F_RLY +: 6]) & ~lock_mask);
          USE_CARD_PIN: next_acc[0] = 1'b1;
          USE_PIN_ONLY: next_acc[1] = 1'b1;
          USE_CARD:     next_acc[2] = 1'b1;
          USE_FLOOR:    next_floor[3'(i - 1)] = 1'b1;
          default:      next_acc = next_acc;
        endcase
      end
      if (on_edge[i] && du[3:0] == USE_EGRESS) next_egs[du[4]] = 1'b1;
      if (flt[i]) next_relay = next_relay | relay_bit(flt_rly);
    end
    for (int c = 0; c < N_CNT; c++) begin
      for (int l = 0; l < N_LIM; l++) begin
        if (lim_on[c][l]) next_relay = next_relay | relay_bit(lim_rly[c][l]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_drive  <= '0;
      door_open    <= '0;
      egress_start <= '0;
      egress_hold  <= '0;
      access_mode  <= '0;
      floor_select <= '0;
    end else begin
      relay_drive  <= next_relay;
      door_open    <= next_door;
      egress_start <= next_egs;
      egress_hold  <= next_egh;
      access_mode  <= next_acc;
      floor_select <= next_floor;
    end
  end

endmodule : icc_top

// File: icc_pkg.sv
package icc_pkg;

  localparam int N_IN  = 9;
  localparam int N_CNT = 16;
  localparam int N_LIM = 4;

  // Register map, byte addresses
  localparam logic [11:0] A_CTRL      = 12'h000;
  localparam logic [11:0] A_STATUS    = 12'h004;
  localparam logic [11:0] A_FLT_RELAY = 12'h008;
  localparam logic [11:0] A_IN_BASE   = 12'h100;
  localparam int          IN_STRIDE   = 8;
  localparam int          OFF_CFG     = 0;
  localparam int          OFF_DLY     = 4;
  localparam logic [11:0] A_CNT_BASE  = 12'h200;
  localparam int          CNT_STRIDE  = 32;
  localparam int          OFF_VAL     = 0;
  localparam int          OFF_RST     = 4;
  localparam int          OFF_RLY     = 8;
  localparam int          OFF_LIM     = 16;

  // Field positions
  localparam int F_POL  = 0;
  localparam int F_TYPE = 1;
  localparam int F_USE  = 4;
  localparam int F_DOOR = 7;
  localparam int F_UP   = 8;
  localparam int F_DN   = 16;
  localparam int F_RLY  = 24;
  localparam int F_OFFD = 16;
  localparam int F_OPT  = 16;
  localparam int F_HYS  = 16;
  localparam int F_FLT  = 16;
  localparam int RLY_STRIDE = 8;

  // Reset values and masks
  localparam logic [31:0] CFG_RST  = 32'h0000_0070;
  localparam logic [31:0] CFG_MASK = 32'h3f1f_1ff7;
  localparam logic [31:0] DLY_MASK = 32'h1fff_1fff;
  localparam logic [5:0]  LOCK_RLY_A = 6'h01;
  localparam logic [5:0]  LOCK_RLY_B = 6'h02;
  localparam logic [5:0]  RLY_MAX    = 6'h24;

  // Timing
  localparam int TICK_MS         = 100;
  localparam int CLK_NS          = 10;
  localparam int ICC_TICK_CYCLES = TICK_MS * 1000000 / CLK_NS;

  typedef enum logic [1:0] {
    two_reader_two_door_mode = 2'b00,
    two_reader_one_door_mode = 2'b01,
    one_reader_one_door_mode = 2'b10,
    lift_control_mode        = 2'b11
  } icc_mode_e;

  typedef enum logic [1:0] {
    TYPE_DIGITAL = 2'b00,
    TYPE_TWO_RES = 2'b01,
    TYPE_ONE_RES = 2'b10
  } icc_type_e;

  typedef enum logic [3:0] {
    USE_NONE     = 4'h0,
    USE_SENSE    = 4'h1,
    USE_EGRESS   = 4'h2,
    USE_RELAY    = 4'h3,
    USE_CARD_PIN = 4'h4,
    USE_PIN_ONLY = 4'h5,
    USE_CARD     = 4'h6,
    USE_DEFAULT  = 4'h7,
    USE_FLOOR    = 4'h8
  } icc_use_e;

  typedef enum logic [1:0] {
    OPT_NEVER = 2'b00,
    OPT_TIMED = 2'b01,
    OPT_NOW   = 2'b10
  } icc_opt_e;

  typedef struct packed {
    logic       valid;
    logic [3:0] idx;
    logic       state;
    logic       fault;
  } icc_event_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] up;
    logic [4:0] dn;
  } icc_grant_s;

endpackage : icc_pkg

// File: icc_assertions.sv
`timescale 1ns/1ps
module icc_assertions import icc_pkg::*; (
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Async reset, active low
  input wire logic        psel,          // APB select
  input wire logic        penable,       // APB enable
  input wire logic        pready,        // APB ready
  input wire logic        pslverr,       // APB error
  input wire logic [36:1] relay_drive,   // Relay requests
  input wire logic [1:0]  egress_start,  // Lock release pulse
  input wire logic [1:0]  egress_hold,   // Lock held released
  input wire icc_event_s  evt            // Event message
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus answers after exactly one wait state
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Outputs quiet on the first edge after reset
  reset_quiet_a: assert property ($rose(presetn) |-> relay_drive == '0 && !pready && !evt.valid)
    else $error("outputs active after reset");
  // A release pulse only ever starts a held release
  egress_pulse_a: assert property (egress_start[0] |=> !egress_start[0])
    else $error("release pulse too long");
  egress_rise_a: assert property ($rose(egress_hold[0]) |-> egress_start[0])
    else $error("hold without release pulse");
  egress_held_a: assert property ((egress_start & ~egress_hold) == 2'b00)
    else $error("release pulse without hold");
  // Events name a real input; the mains input cannot report tamper
  evt_range_a: assert property (evt.valid |-> evt.idx <= 4'h8)
    else $error("event from unknown input");
  evt_zero_a: assert property (evt.valid && evt.idx == 4'h0 |-> !evt.fault)
    else $error("fault on input zero");

  cover property (evt.valid && evt.state);
  cover property (pslverr);
  cover property (egress_start[0]);
endmodule : icc_assertions

// File: icc_contacts.sv
`timescale 1ns/1ps
module icc_contacts (
  input  wire logic       pclk,        // Clock
  input  wire logic [7:0] closed,      // Wanted switch states
  input  wire logic       power_lost,  // Wanted mains state
  input  wire logic [7:0] shorted,     // Loops wired short
  input  wire logic [7:0] cut,         // Loops wired open
  output logic      [7:0] in_contact,  // Contact levels
  output logic      [7:0] in_short,    // Short flags
  output logic      [7:0] in_open,     // Open flags
  output logic            mains_fail   // Mains lost
);
  // Switches and loop faults move just after an edge, never on it
  always @(posedge pclk) begin
    in_contact <= closed;
    in_short   <= shorted;
    in_open    <= cut;
    mains_fail <= power_lost;
  end
endmodule : icc_contacts

// File: tb_input_conditioning_counters.sv
`timescale 1ns/1ps
module tb_input_conditioning_counters import icc_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mains_fail, power_lost, timed_reset, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0]  in_contact, in_short, in_open, closed, floor_select, shorted, cut;
  logic [36:1] relay_drive;
  logic [1:0]  door_open, egress_start, egress_hold;
  logic [2:0]  access_mode;
  icc_grant_s  grant;
  icc_event_s  evt;
  int          num_errors, checks, evt_cnt, e0;

  icc_top #(.TICK_CYCLES(4)) icc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_contact(in_contact), .in_short(in_short), .in_open(in_open), .mains_fail(mains_fail), .grant(grant),
    .timed_reset(timed_reset), .relay_drive(relay_drive), .door_open(door_open), .egress_start(egress_start),
    .egress_hold(egress_hold), .access_mode(access_mode), .floor_select(floor_select), .evt(evt));
  icc_contacts icc_contacts_inst (.pclk(pclk), .closed(closed), .power_lost(power_lost), .shorted(shorted), .cut(cut),
    .in_contact(in_contact), .in_short(in_short), .in_open(in_open), .mains_fail(mains_fail));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Count event messages as they pass
  always @(posedge pclk) begin
    if (evt.valid === 1'b1) evt_cnt <= evt_cnt + 1;
  end

  function automatic logic [11:0] ia(input int i);
    return A_IN_BASE + 12'(IN_STRIDE * i);
  endfunction : ia
  function automatic logic [11:0] ca(input int c, input int o);
    return A_CNT_BASE + 12'(CNT_STRIDE * c + o);
  endfunction : ca

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until ready is sampled
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, rdat, e);
  endtask : rchk
  task automatic gnt(input logic [4:0] u, input logic [4:0] dn);
    @(posedge pclk);
    grant <= {1'b1, u, dn};
    @(posedge pclk);
    grant <= '0;
  endtask : gnt

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    conclude();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    grant = '0; timed_reset = 1'b0; closed = 8'h00; power_lost = 1'b0; shorted = 8'h00; cut = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk("cfg1", ia(1), CFG_RST);
    rchk("dly1", ia(1) + 12'h4, 32'h0);
    rchk("cnt0", ca(0, OFF_VAL), 32'h0);
    rchk("rst0", ca(0, OFF_RST), 32'h0);
    rchk("unmapped", 12'hffc, 32'h0);
    chk("slverr", rerr, 32'h1);
    $display("test defaults done");
    // Input 5 normally closed, 6 drives relay 10 and counter 1 with delay, 7 selects card+PIN
    wr(A_CTRL, 32'h0);
    wr(ia(0), 32'h2);
    rchk("type0", ia(0), 32'h0);
    wr(ia(5), 32'h1);
    wr(ia(6), 32'h0a00_0130);
    wr(ia(6) + 12'h4, 32'h3);
    wr(ia(7), 32'h40);
    closed <= 8'h20;
    repeat (5) @(posedge pclk);
    closed <= 8'h00;
    repeat (30) @(posedge pclk);
    rchk("glitch", ca(0, OFF_VAL), 32'h0);
    e0 = evt_cnt;
    closed <= 8'h63;
    power_lost <= 1'b1;
    repeat (40) @(posedge pclk);
    xfer(1'b0, A_STATUS, 32'h0);
    chk("qual", rdat & 32'h1ff, 32'h0e7);
    chk("door", door_open, 32'h1);
    chk("egress", egress_hold, 32'h1);
    chk("follow", relay_drive[10], 32'h1);
    chk("mode", access_mode, 32'h1);
    rchk("upcnt", ca(0, OFF_VAL), 32'h1);
    chk("events", evt_cnt - e0, 32'h5);
    closed <= 8'h00;
    power_lost <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("door_off", door_open, 32'h0);
    chk("follow_off", relay_drive[10], 32'h0);
    chk("mode_off", access_mode, 32'h0);
    chk("events_off", evt_cnt - e0, 32'ha);
    rchk("upcnt_off", ca(0, OFF_VAL), 32'h1);
    $display("test inputs done");
    // Input 3 tamper: two-resistor flags open, one-resistor only short
    wr(A_FLT_RELAY, 32'h14);
    wr(ia(3), 32'h72);
    cut <= 8'h04;
    repeat (10) @(posedge pclk);
    xfer(1'b0, A_STATUS, 32'h0);
    chk("fault2r", rdat >> 16, 32'h8);
    chk("flt_rly", relay_drive[20], 32'h1);
    wr(ia(3), 32'h74);
    repeat (10) @(posedge pclk);
    chk("open1r", relay_drive[20], 32'h0);
    shorted <= 8'h04;
    repeat (10) @(posedge pclk);
    chk("short1r", relay_drive[20], 32'h1);
    shorted <= 8'h00;
    cut <= 8'h00;
    // Lock relay refused in door mode, allowed in lift mode
    wr(ia(6), 32'h0100_0030);
    closed <= 8'h21;
    repeat (30) @(posedge pclk);
    chk("lock_excl", relay_drive[1], 32'h0);
    wr(A_CTRL, 32'h3);
    repeat (6) @(posedge pclk);
    chk("lift_rly", relay_drive[1], 32'h1);
    chk("floor", floor_select, 32'h01);
    chk("lift_door", door_open, 32'h0);
    closed <= 8'h00;
    repeat (20) @(posedge pclk);
    chk("floor_off", floor_select, 32'h00);
    $display("test tamper and modes done");
    // Counter 2: saturation, hysteresis, latch and resets
    wr(ca(1, OFF_VAL), 32'hffff);
    gnt(5'd2, 5'd0);
    rchk("sat_hi", ca(1, OFF_VAL), 32'hffff);
    wr(ca(1, OFF_VAL), 32'h0);
    gnt(5'd0, 5'd2);
    rchk("sat_lo", ca(1, OFF_VAL), 32'h0);
    wr(ca(1, OFF_LIM), 32'h0001_0003);
    wr(ca(1, OFF_RLY), 32'h0c);
    repeat (3) gnt(5'd2, 5'd0);
    repeat (4) @(posedge pclk);
    chk("lim_on", relay_drive[12], 32'h1);
    wr(ca(1, OFF_VAL), 32'h2);
    repeat (4) @(posedge pclk);
    chk("lim_hys", relay_drive[12], 32'h1);
    wr(ca(1, OFF_VAL), 32'h1);
    repeat (4) @(posedge pclk);
    chk("lim_off", relay_drive[12], 32'h0);
    wr(ca(1, OFF_LIM), 32'h0003_0003);
    wr(ca(1, OFF_VAL), 32'h3);
    wr(ca(1, OFF_VAL), 32'h0);
    repeat (4) @(posedge pclk);
    chk("latch", relay_drive[12], 32'h1);
    wr(ca(1, OFF_RST), 32'h0002_0001);
    repeat (4) @(posedge pclk);
    chk("unlatch", relay_drive[12], 32'h0);
    rchk("rst_now", ca(1, OFF_VAL), 32'h1);
    rchk("opt_clr", ca(1, OFF_RST), 32'h1);
    wr(ca(1, OFF_RST), 32'h0001_0007);
    rchk("no_pulse", ca(1, OFF_VAL), 32'h1);
    @(posedge pclk);
    timed_reset <= 1'b1;
    @(posedge pclk);
    timed_reset <= 1'b0;
    rchk("timed", ca(1, OFF_VAL), 32'h7);
    wr(ca(15, OFF_VAL), 32'h1234);
    rchk("cnt16", ca(15, OFF_VAL), 32'h1234);
    $display("test counters done");
    conclude();
  end
endmodule : tb_input_conditioning_counters

bind icc_top icc_assertions icc_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .relay_drive(relay_drive), .egress_start(egress_start),
  .egress_hold(egress_hold), .evt(evt));
